// [dv/smbw_chk.sv]
// checker: timing relations on the two-wire link
`timescale 1ns/1ps
`default_nettype none
module smbw_chk (
    // clock, reset and link wires
    input wire logic clk,
    input wire logic srst,
    input wire logic hostSclOe,
    input wire logic hostSdaOe,
    input wire logic devSdaOe,
    input wire logic sclLine,
    input wire logic sdaLine
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    AST_ACK_RISE_LOW: assert property ($rose(devSdaOe) |-> !sclLine)
        else $error("ack raised while clock high");
    AST_ACK_FALL_LOW: assert property ($fell(devSdaOe) |-> !sclLine)
        else $error("ack dropped while clock high");
    AST_ACK_HELD: assert property ($rose(devSdaOe) |-> devSdaOe[*8])
        else $error("ack too short");
    AST_ACK_ENDS: assert property ($rose(devSdaOe) |-> ##[1:60] !devSdaOe)
        else $error("ack not released");
    AST_HOST_FREE: assert property (devSdaOe && sclLine |-> !hostSdaOe)
        else $error("host drives data in ack slot");
    AST_START: assert property ($fell(sdaLine) && sclLine |-> ##[1:20] !sclLine)
        else $error("no clock after start");
    AST_STOP: assert property ($rose(sdaLine) && sclLine |-> sclLine[*4])
        else $error("clock low right after stop");
    AST_SCL_HIGH: assert property ($fell(hostSclOe) |-> sclLine[*4])
        else $error("clock high phase too short");
endmodule
`default_nettype wire

// [dv/smbw_tb.sv]
// testbench: host end and device end joined over the link
`timescale 1ns/1ps
`default_nettype none
module smbw_tb;
    // stimulus and observed signals
    logic clk = 1'b0, srst = 1'b1, refClkRunning = 1'b1, cmdValid = 1'b0, txValid = 1'b0;
    logic [7:0] cmdAddr = 8'h00, cmdIndex = 8'h00, cmdCount = 8'h00, txData = 8'h00;
    logic [3:0] straps = 4'h0;
    logic cmdReady, txReady, done, nack, wrStrobe, devActive, addrValid;
    logic [7:0] wrIndex, wrData;
    logic [7:0] gotIdx [$], gotDat [$];
    int mismatches = 0, num_checks = 0, cyc = 0;
    localparam logic [7:0] ADDRS [8] = '{smbw_pkg::ADDR_LL, smbw_pkg::ADDR_LM, smbw_pkg::ADDR_LH,
        smbw_pkg::ADDR_ML, smbw_pkg::ADDR_MM, smbw_pkg::ADDR_MH, smbw_pkg::ADDR_HL, smbw_pkg::ADDR_HM};
    smbw_link_if bus ();
    smbw_dev_end i_smbw_dev_end (.clk(clk), .srst(srst), .refClkRunning(refClkRunning),
        .bus_addr_strap_pins(straps), .wrStrobe(wrStrobe), .wrIndex(wrIndex), .wrData(wrData),
        .devActive(devActive), .addrValid(addrValid), .bus(bus));
    smbw_host_end i_smbw_host_end (.clk(clk), .srst(srst), .refClkRunning(refClkRunning),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdAddr(cmdAddr), .cmdIndex(cmdIndex),
        .cmdCount(cmdCount), .txValid(txValid), .txReady(txReady), .txData(txData),
        .done(done), .nack(nack), .bus(bus));
    smbw_chk i_smbw_chk (.clk(clk), .srst(srst), .hostSclOe(bus.hostSclOe),
        .hostSdaOe(bus.hostSdaOe), .devSdaOe(bus.devSdaOe), .sclLine(bus.sclLine),
        .sdaLine(bus.sdaLine));
    // clock
    initial forever #50 clk = ~clk;
    // collect register writes, cut a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (wrStrobe === 1'b1) begin
            gotIdx.push_back(wrIndex);
            gotDat.push_back(wrData);
        end
        if (cyc == 40000) begin
            mismatches++;
            wrap_up();
        end
    end
    // compare one value
    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask
    // counts and verdict
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one block write, data byte k is the inverse of index plus k
    task automatic frame(input logic [7:0] a, i, c, input logic en, input logic [7:0] nw);
        int k;
        k = 0;
        gotIdx.delete();
        gotDat.delete();
        for (int w = 0; w < 50 && cmdReady !== 1'b1; w++) @(posedge clk);
        cmdAddr <= a;
        cmdIndex <= i;
        cmdCount <= c;
        cmdValid <= 1'b1;
        @(posedge clk);
        cmdValid <= 1'b0;
        txData <= ~i;
        txValid <= 1'b1;
        while (done !== 1'b1) begin
            @(posedge clk);
            if (txValid && txReady) begin
                k++;
                txData <= ~(i + 8'(k));
            end
        end
        txValid <= 1'b0;
        @(posedge clk);
        check("nack", {7'h00, en}, {7'h00, nack});
        check("writes", nw, 8'(gotIdx.size()));
        for (int j = 0; j < nw; j++) begin
            check("index", i + 8'(j), gotIdx[j]);
            check("data", ~(i + 8'(j)), gotDat[j]);
        end
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        check("devActive", 8'h01, {7'h00, devActive});
        for (int j = 0; j < 8; j++) begin
            straps <= {2'(j / 3), 2'(j % 3)};
            repeat (4) @(posedge clk);
            check("addrValid", 8'h01, {7'h00, addrValid});
            frame(ADDRS[j], 8'(j * 16), 8'h02, 1'b0, 8'h02);
        end
        frame(ADDRS[0], 8'h10, 8'h01, 1'b1, 8'h00);
        frame(ADDRS[7], 8'hFE, 8'h03, 1'b0, 8'h03);
        frame(ADDRS[7] | 8'h01, 8'h20, 8'h00, 1'b0, 8'h00);
        straps <= 4'hA;
        repeat (4) @(posedge clk);
        check("addrValid", 8'h00, {7'h00, addrValid});
        refClkRunning <= 1'b0;
        repeat (4) @(posedge clk);
        check("cmdReady", 8'h00, {7'h00, cmdReady});
        check("devActive", 8'h00, {7'h00, devActive});
        wrap_up();
    end
endmodule
`default_nettype wire

// [verilog/smbw_dev_end.sv]
// device end: strap-addressed indexed block write receiver
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - host opens every write with start
// - write address sent, device acknowledges match
// - index byte acknowledged, held as start
// - byte count acknowledged by device
// - data stored at index, index increments
// - every data byte within the count gets its own acknowledge
// - host closes with stop after last
// - straps select one of eight addresses
// - each strap resolves low, mid, high
// - link works only while reference runs
module smbw_dev_end (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // reference clock presence, asynchronous level
    input  wire logic       refClkRunning,
    // strap levels {pin1, pin0}, two bits each, asynchronous
    input  wire logic [3:0] bus_addr_strap_pins,
    // register write port
    output logic            wrStrobe,
    output logic [7:0]      wrIndex,
    output logic [7:0]      wrData,
    // status
    output logic            devActive,
    output logic            addrValid,
    // link
    smbw_link_if.dev        bus
);

    // ***************************************************
    // state record
    // ***************************************************
    typedef struct packed {
        logic [1:0]               sclSync;  // clock wire synchroniser
        logic [1:0]               sdaSync;  // data wire synchroniser
        logic                     sclPrev;  // last settled clock level
        logic                     sdaPrev;  // last settled data level
        logic [1:0]               refSync;  // reference presence synchroniser
        logic [3:0]               strapS0;  // strap synchroniser, first stage
        logic [3:0]               strapS1;  // strap synchroniser, second stage
        smbw_pkg::smbw_dev_state_t state;   // byte being received
        logic [3:0]               bitCnt;   // bits shifted in this byte
        logic                     inAck;    // acknowledge slot in progress
        logic [7:0]               shift;    // incoming byte
        logic [7:0]               index;    // next register location
        logic [7:0]               remain;   // data bytes still expected
        logic                     sdaOe;    // pulling data low for acknowledge
        logic                     wrStrobe; // write pulse
        logic [7:0]               wrIndex;  // written location
        logic [7:0]               wrData;   // written value
    } smbw_dev_st_t;

    smbw_dev_st_t r;    // registered state
    smbw_dev_st_t nxt;  // next state

    // ***************************************************
    // settled line events
    // ***************************************************
    logic sclRise;    // clock wire went high
    logic sclFall;    // clock wire went low
    logic startSeen;  // data fell with clock high
    logic stopSeen;   // data rose with clock high
    logic active;     // reference clock present

    assign sclRise   = r.sclSync[1] && !r.sclPrev;
    assign sclFall   = !r.sclSync[1] && r.sclPrev;
    // start and stop only count while the clock stays high
    assign startSeen = r.sclSync[1] && r.sclPrev && !r.sdaSync[1] && r.sdaPrev;
    assign stopSeen  = r.sclSync[1] && r.sclPrev && r.sdaSync[1] && !r.sdaPrev;
    assign active    = r.refSync[1];

    // ***************************************************
    // strap decode
    // ***************************************************
    logic [7:0] myAddr;   // selected write address
    logic       myValid;  // strap pair has an address

    // unlisted pairs and illegal codes leave the device deaf
    always_comb begin
        myAddr  = 8'h00;
        myValid = 1'b1;
        unique case ({r.strapS1[3:2], r.strapS1[1:0]})
            {smbw_pkg::LVL_LOW,  smbw_pkg::LVL_LOW}:  myAddr = smbw_pkg::ADDR_LL;
            {smbw_pkg::LVL_LOW,  smbw_pkg::LVL_MID}:  myAddr = smbw_pkg::ADDR_LM;
            {smbw_pkg::LVL_LOW,  smbw_pkg::LVL_HIGH}: myAddr = smbw_pkg::ADDR_LH;
            {smbw_pkg::LVL_MID,  smbw_pkg::LVL_LOW}:  myAddr = smbw_pkg::ADDR_ML;
            {smbw_pkg::LVL_MID,  smbw_pkg::LVL_MID}:  myAddr = smbw_pkg::ADDR_MM;
            {smbw_pkg::LVL_MID,  smbw_pkg::LVL_HIGH}: myAddr = smbw_pkg::ADDR_MH;
            {smbw_pkg::LVL_HIGH, smbw_pkg::LVL_LOW}:  myAddr = smbw_pkg::ADDR_HL;
            {smbw_pkg::LVL_HIGH, smbw_pkg::LVL_MID}:  myAddr = smbw_pkg::ADDR_HM;
            default: begin
                // high/high or an undefined level code
                myValid = 1'b0;
            end
        endcase
    end

    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        nxt = r;
        // pulses last one cycle
        nxt.wrStrobe = 1'b0;
        // synchronisers; first stages feed only second stages
        nxt.sclSync = {r.sclSync[0], bus.sclLine};
        nxt.sdaSync = {r.sdaSync[0], bus.sdaLine};
        nxt.refSync = {r.refSync[0], refClkRunning};
        nxt.strapS0 = bus_addr_strap_pins;
        nxt.strapS1 = r.strapS0;
        // edge history from settled stages
        nxt.sclPrev = r.sclSync[1];
        nxt.sdaPrev = r.sdaSync[1];

        if (!active) begin
            // stopped reference: drop any transfer and release the wire
            nxt.state = smbw_pkg::DEV_IDLE;
            nxt.inAck = 1'b0;
            nxt.sdaOe = 1'b0;
        end else if (startSeen) begin
            // a start, repeated or not, always restarts framing
            nxt.state  = smbw_pkg::DEV_ADDR;
            nxt.bitCnt = 4'h0;
            nxt.inAck  = 1'b0;
            nxt.sdaOe  = 1'b0;
        end else if (stopSeen) begin
            // stop ends the transaction
            nxt.state = smbw_pkg::DEV_IDLE;
            nxt.inAck = 1'b0;
            nxt.sdaOe = 1'b0;
        end else if (r.state != smbw_pkg::DEV_IDLE && r.state != smbw_pkg::DEV_IGNORE) begin
            if (sclRise && !r.inAck && r.bitCnt < smbw_pkg::ACK_SLOT) begin
                // data sampled on the rising clock, msb first
                nxt.shift  = {r.shift[6:0], r.sdaSync[1]};
                nxt.bitCnt = r.bitCnt + 4'h1;
            end else if (sclFall && r.inAck) begin
                // acknowledge slot over, release the wire
                nxt.inAck  = 1'b0;
                nxt.sdaOe  = 1'b0;
                nxt.bitCnt = 4'h0;
            end else if (sclFall && r.bitCnt == smbw_pkg::ACK_SLOT) begin
                // byte complete: decide the acknowledge
                nxt.inAck = 1'b1;
                unique case (r.state)
                    smbw_pkg::DEV_ADDR: begin
                        if (myValid && r.shift[7:1] == myAddr[7:1]
                                && r.shift[0] == smbw_pkg::WR_FLAG) begin
                            nxt.sdaOe = 1'b1;
                            nxt.state = smbw_pkg::DEV_INDEX;
                        end else begin
                            // other address or a read: stay silent
                            nxt.state = smbw_pkg::DEV_IGNORE;
                        end
                    end
                    smbw_pkg::DEV_INDEX: begin
                        // first location to write
                        nxt.index = r.shift;
                        nxt.sdaOe = 1'b1;
                        nxt.state = smbw_pkg::DEV_COUNT;
                    end
                    smbw_pkg::DEV_COUNT: begin
                        // number of data bytes that follow
                        nxt.remain = r.shift;
                        nxt.sdaOe  = 1'b1;
                        nxt.state  = smbw_pkg::DEV_DATA;
                    end
                    smbw_pkg::DEV_DATA: begin
                        if (r.remain != 8'h00) begin
                            // store and step to the next location
                            nxt.wrStrobe = 1'b1;
                            nxt.wrIndex  = r.index;
                            nxt.wrData   = r.shift;
                            nxt.index    = r.index + 8'h01;
                            nxt.remain   = r.remain - 8'h01;
                            nxt.sdaOe    = 1'b1;
                        end else begin
                            // bytes beyond the count are refused
                            nxt.state = smbw_pkg::DEV_IGNORE;
                        end
                    end
                    default: begin
                        nxt.state = smbw_pkg::DEV_IGNORE;
                    end
                endcase
            end
        end
    end

    // ***************************************************
    // state register
    // ***************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            r         <= '0;
            r.sclSync <= 2'h3;
            r.sdaSync <= 2'h3;
            r.sclPrev <= 1'b1;
            r.sdaPrev <= 1'b1;
            r.state   <= smbw_pkg::DEV_IDLE;
        end else begin
            r <= nxt;
        end
    end

    // ***************************************************
    // outputs
    // ***************************************************
    assign wrStrobe      = r.wrStrobe;
    assign wrIndex       = r.wrIndex;
    assign wrData        = r.wrData;
    assign devActive     = r.refSync[1];
    assign addrValid     = myValid;
    // open drain: only ever pulls low
    assign bus.devSdaOut = 1'b0;
    assign bus.devSdaOe  = r.sdaOe;

endmodule

`default_nettype wire

// [verilog/smbw_host_end.sv]
// host end: issues one indexed block write per command
`timescale 1ns/1ps
`default_nettype none

module smbw_host_end #(
    parameter int unsigned QUARTER_CYC = smbw_pkg::QUARTER_CYC  // cycles per quarter bit
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // reference clock presence at the device, asynchronous level
    input  wire logic       refClkRunning,
    // command
    input  wire logic       cmdValid,
    output logic            cmdReady,
    input  wire logic [7:0] cmdAddr,
    input  wire logic [7:0] cmdIndex,
    input  wire logic [7:0] cmdCount,
    // data bytes, one per handshake
    input  wire logic       txValid,
    output logic            txReady,
    input  wire logic [7:0] txData,
    // result
    output logic            done,
    output logic            nack,
    // link
    smbw_link_if.host       bus
);

    // refuse dividers that cannot space the line changes
    if (QUARTER_CYC < 2 || QUARTER_CYC > 255) begin : g_bad_div
        $error("QUARTER_CYC out of range");
    end

    // ***************************************************
    // state record
    // ***************************************************
    typedef struct packed {
        smbw_pkg::smbw_hst_state_t state;  // framing step
        smbw_pkg::smbw_sel_t       sel;    // byte being sent
        logic [7:0] tick;     // cycles into the quarter
        logic [1:0] phase;    // quarter of the bit
        logic [3:0] bitCnt;   // bit slot in the byte
        logic [7:0] shift;    // outgoing byte
        logic [7:0] addr;     // device address
        logic [7:0] index;    // first location
        logic [7:0] count;    // byte count
        logic [7:0] remain;   // data bytes still to send
        logic       sclLow;   // pulling clock low
        logic       sdaLow;   // pulling data low
        logic       ackBit;   // sampled acknowledge level
        logic [1:0] sdaSync;  // data wire synchroniser
        logic [1:0] refSync;  // reference presence synchroniser
        logic       done;     // transaction finished pulse
        logic       nack;     // last transaction refused
    } smbw_hst_st_t;

    smbw_hst_st_t r;    // registered state
    smbw_hst_st_t nxt;  // next state

    logic qEnd;  // last cycle of a quarter
    assign qEnd = (r.tick == 8'(QUARTER_CYC - 1));

    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        nxt         = r;
        nxt.done    = 1'b0;
        nxt.sdaSync = {r.sdaSync[0], bus.sdaLine};
        nxt.refSync = {r.refSync[0], refClkRunning};
        nxt.tick    = qEnd ? 8'h00 : r.tick + 8'h01;
        unique case (r.state)
            smbw_pkg::HST_IDLE: begin
                nxt.tick = 8'h00;
                // no command while the device reference is stopped
                if (cmdValid && r.refSync[1]) begin
                    nxt.addr   = cmdAddr;
                    nxt.index  = cmdIndex;
                    nxt.count  = cmdCount;
                    nxt.nack   = 1'b0;
                    nxt.phase  = 2'h0;
                    nxt.state  = smbw_pkg::HST_START;
                end
            end
            smbw_pkg::HST_START: begin
                // data falls while clock high, then clock falls
                if (qEnd) begin
                    nxt.phase = r.phase + 2'h1;
                    if (r.phase == 2'h0) nxt.sdaLow = 1'b1;
                    if (r.phase == 2'h2) nxt.sclLow = 1'b1;
                    if (r.phase == 2'h3) begin
                        nxt.sel   = smbw_pkg::SEL_ADDR;
                        nxt.state = smbw_pkg::HST_LOAD;
                    end
                end
            end
            smbw_pkg::HST_LOAD: begin
                // clock held low while the next byte is chosen
                nxt.tick   = 8'h00;
                nxt.phase  = 2'h0;
                nxt.bitCnt = 4'h0;
                unique case (r.sel)
                    smbw_pkg::SEL_ADDR:  nxt.shift = {r.addr[7:1], smbw_pkg::WR_FLAG};
                    smbw_pkg::SEL_INDEX: nxt.shift = r.index;
                    smbw_pkg::SEL_COUNT: nxt.shift = r.count;
                    smbw_pkg::SEL_DATA:  nxt.shift = txData;
                endcase
                if (r.sel == smbw_pkg::SEL_DATA && r.remain == 8'h00) begin
                    // all data sent: close with stop
                    nxt.sdaLow = 1'b1;
                    nxt.state  = smbw_pkg::HST_STOP;
                end else if (r.sel != smbw_pkg::SEL_DATA || txValid) begin
                    nxt.sdaLow = (r.sel == smbw_pkg::SEL_ADDR) ? !r.addr[7]
                               : (r.sel == smbw_pkg::SEL_INDEX) ? !r.index[7]
                               : (r.sel == smbw_pkg::SEL_COUNT) ? !r.count[7] : !txData[7];
                    if (r.sel == smbw_pkg::SEL_DATA) nxt.remain = r.remain - 8'h01;
                    if (r.sel == smbw_pkg::SEL_COUNT) nxt.remain = r.count;
                    nxt.state = smbw_pkg::HST_BIT;
                end
            end
            smbw_pkg::HST_BIT: begin
                if (qEnd) begin
                    nxt.phase = r.phase + 2'h1;
                    if (r.phase == 2'h0) nxt.sclLow = 1'b0;
                    if (r.phase == 2'h2) begin
                        nxt.sclLow = 1'b1;
                        nxt.ackBit = r.sdaSync[1];
                    end
                    if (r.phase == 2'h3) begin
                        if (r.bitCnt < smbw_pkg::ACK_SLOT) begin
                            // next bit, or release the wire for the acknowledge
                            nxt.shift  = {r.shift[6:0], 1'b0};
                            nxt.bitCnt = r.bitCnt + 4'h1;
                            nxt.sdaLow = (r.bitCnt < 4'h7) ? !r.shift[6] : 1'b0;
                        end else if (r.ackBit) begin
                            // refused: stop at once
                            nxt.nack   = 1'b1;
                            nxt.sdaLow = 1'b1;
                            nxt.state  = smbw_pkg::HST_STOP;
                        end else begin
                            // step to the next byte kind; data bytes repeat
                            if (r.sel != smbw_pkg::SEL_DATA) begin
                                nxt.sel = smbw_pkg::smbw_sel_t'(r.sel + 2'h1);
                            end
                            nxt.state = smbw_pkg::HST_LOAD;
                        end
                    end
                end
            end
            smbw_pkg::HST_STOP: begin
                // clock rises, then data rises with clock high
                if (qEnd) begin
                    nxt.phase = r.phase + 2'h1;
                    if (r.phase == 2'h0) nxt.sclLow = 1'b0;
                    if (r.phase == 2'h1) nxt.sdaLow = 1'b0;
                    if (r.phase == 2'h3) begin
                        nxt.done  = 1'b1;
                        nxt.state = smbw_pkg::HST_IDLE;
                    end
                end
            end
            default: nxt.state = smbw_pkg::HST_IDLE;
        endcase
    end

    // ***************************************************
    // state register
    // ***************************************************
    always_ff @(posedge clk) begin
        if (srst) begin
            r         <= '0;
            r.state   <= smbw_pkg::HST_IDLE;
            r.sdaSync <= 2'h3;
        end else begin
            r <= nxt;
        end
    end

    // ***************************************************
    // outputs
    // ***************************************************
    assign cmdReady       = (r.state == smbw_pkg::HST_IDLE) && r.refSync[1];
    assign txReady        = (r.state == smbw_pkg::HST_LOAD) && (r.sel == smbw_pkg::SEL_DATA)
                            && (r.remain != 8'h00);
    assign done           = r.done;
    assign nack           = r.nack;
    assign bus.hostSclOut = 1'b0;
    assign bus.hostSclOe  = r.sclLow;
    assign bus.hostSdaOut = 1'b0;
    assign bus.hostSdaOe  = r.sdaLow;

endmodule

`default_nettype wire

// [verilog/smbw_link_if.sv]
// two-wire open-drain link joining the host end and the device end
`timescale 1ns/1ps
`default_nettype none

interface smbw_link_if;

    // ***************************************************
    // pin drivers, each end drives only its own
    // ***************************************************
    logic hostSclOut;  // host clock level when driving
    logic hostSclOe;   // host drives the clock wire
    logic hostSdaOut;  // host data level when driving
    logic hostSdaOe;   // host drives the data wire
    logic devSdaOut;   // device data level when driving
    logic devSdaOe;    // device drives the data wire

    // ***************************************************
    // resolved wire levels, pulled up when nobody drives low
    // ***************************************************
    logic sclLine;     // clock wire
    logic sdaLine;     // data wire

    assign sclLine = !(hostSclOe && !hostSclOut);
    assign sdaLine = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

    // host end
    modport host (
        output hostSclOut, hostSclOe, hostSdaOut, hostSdaOe,
        input  sclLine, sdaLine
    );

    // device end
    modport dev (
        output devSdaOut, devSdaOe,
        input  sclLine, sdaLine
    );

endinterface

`default_nettype wire

// [verilog/smbw_pkg.sv]
// shared constants and types for the indexed block write serial link
`default_nettype none

package smbw_pkg;

    // ***************************************************
    // link timing
    // ***************************************************
    localparam int unsigned CLK_PERIOD_NS = 100;   // system clock period
    localparam int unsigned SCL_PERIOD_NS = 2500;  // host bus clock period (400 kHz)
    // quarter of a bus clock period in system cycles, rounded up
    localparam int unsigned QUARTER_CYC =
        (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

    // ***************************************************
    // byte framing
    // ***************************************************
    localparam logic [3:0] ACK_SLOT = 4'h8;  // bit slot that carries the acknowledge
    localparam logic       WR_FLAG  = 1'b0;  // read/write flag value for a write

    // ***************************************************
    // three-level strap encoding, one field per strap pin
    // ***************************************************
    localparam logic [1:0] LVL_LOW  = 2'h0;  // pin tied low
    localparam logic [1:0] LVL_MID  = 2'h1;  // pin near half supply
    localparam logic [1:0] LVL_HIGH = 2'h2;  // pin tied high

    // ***************************************************
    // write addresses selected by the straps {pin1, pin0}
    // ***************************************************
    localparam logic [7:0] ADDR_LL = 8'hD8;
    localparam logic [7:0] ADDR_LM = 8'hDA;
    localparam logic [7:0] ADDR_LH = 8'hDE;
    localparam logic [7:0] ADDR_ML = 8'hC2;
    localparam logic [7:0] ADDR_MM = 8'hC4;
    localparam logic [7:0] ADDR_MH = 8'hC6;
    localparam logic [7:0] ADDR_HL = 8'hCA;
    localparam logic [7:0] ADDR_HM = 8'hCC;

    // ***************************************************
    // state machines
    // ***************************************************
    // device end: which byte of the transaction is being received
    typedef enum logic [2:0] {
        DEV_IDLE, DEV_ADDR, DEV_INDEX, DEV_COUNT, DEV_DATA, DEV_IGNORE
    } smbw_dev_state_t;

    // host end: framing steps
    typedef enum logic [2:0] {
        HST_IDLE, HST_START, HST_LOAD, HST_BIT, HST_STOP
    } smbw_hst_state_t;

    // host end: which byte is sent next
    typedef enum logic [1:0] {
        SEL_ADDR, SEL_INDEX, SEL_COUNT, SEL_DATA
    } smbw_sel_t;

endpackage

`default_nettype wire

// [verilog/smbw_pkg_end.sv]
// no logic here: link constants and types live in the shared package
